/* calib_pkg.sv */
`default_nettype none
package calib_pkg;
	localparam int          MEM_DEPTH     = 32;
	localparam int          ADDR_W        = 5;
	localparam int          PTR_W         = 6;
	localparam int          BURST_LEN     = 8;
	localparam logic [7:0]  LAST_ADDR     = 8'h1F;
	localparam logic [7:0]  FILL_BYTE     = 8'hFF;
	localparam logic [1:0]  ARG_RSVD      = 2'h0;
	localparam int          TURN_NS       = 55000;
	localparam int          CLK_NS        = 8;
	localparam int          TURN_CYC      = (TURN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0]  ID_LOW_ADDR   = 5'h00;
	localparam logic [4:0]  ID_MID_ADDR   = 5'h01;
	localparam logic [4:0]  ID_HIGH_ADDR  = 5'h02;
	localparam int          WAFER_W       = 5;
	localparam logic [4:0]  CHECK_ADDR    = 5'h1F;
	// colour blocks: red, blue, green in memory order
	localparam logic [4:0]  RED_BASE      = 5'h0A;
	localparam logic [4:0]  BLUE_BASE     = 5'h11;
	localparam logic [4:0]  GREEN_BASE    = 5'h18;
	localparam logic [4:0]  OFS_U_NIGHT   = 5'h00;
	localparam logic [4:0]  OFS_V_NIGHT   = 5'h01;
	localparam logic [4:0]  OFS_LUM_NIGHT = 5'h02;
	localparam logic [4:0]  OFS_LUM_HIGH  = 5'h03;
	localparam logic [4:0]  OFS_U_DAY     = 5'h04;
	localparam logic [4:0]  OFS_V_DAY     = 5'h05;
	localparam logic [4:0]  OFS_LUM_DAY   = 5'h06;
	localparam int          FIFO_DEPTH    = 8;
endpackage
`default_nettype wire

/* calib_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface calib_link_if;
	logic       cmd_valid;
	logic       cmd_ready;
	logic [7:0] cmd_arg;
	logic       rsp_valid;
	logic       rsp_ready;
	logic [7:0] rsp_byte;
	logic       rsp_last;
	modport device (input cmd_valid, cmd_arg, rsp_ready,
		output cmd_ready, rsp_valid, rsp_byte, rsp_last);
	modport host (output cmd_valid, cmd_arg, rsp_ready,
		input cmd_ready, rsp_valid, rsp_byte, rsp_last);
endinterface
`default_nettype wire

/* calib_responder.sv */
`timescale 1ns/1ps
`default_nettype none
// byte fifo between memory fetch and link
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rstn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    wr_d;
	logic [PW-1:0]    rd_q;
	logic [PW-1:0]    rd_d;
	logic [PW:0]      cnt_q;
	logic [PW:0]      cnt_d;
	logic             push;
	logic             pop;

	// pointer and level next values
	always_comb
	begin
		push  = i_in_valid && o_in_ready;
		pop   = o_out_valid && i_out_ready;
		wr_d  = push ? PW'(wr_q + 1'b1) : wr_q;
		rd_d  = pop ? PW'(rd_q + 1'b1) : rd_q;
		cnt_d = (PW+1)'(cnt_q + (PW+1)'(push) - (PW+1)'(pop));
	end

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage, no reset needed
	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem_q[wr_q] <= i_in_data;
	end

	assign o_in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem_q[rd_q];
endmodule // byte_fifo

// device end: calibration memory and fetch command responder
module calib_responder
	import calib_pkg::*;
#(
	parameter int TURN = TURN_CYC
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	calib_link_if.device     link,
	input  wire logic        i_prog_we,
	input  wire logic [4:0]  i_prog_addr,
	input  wire logic [7:0]  i_prog_data,
	output logic             o_busy,
	output logic      [15:0] o_die_position,
	output logic      [4:0]  o_wafer_number,
	output logic [2:0][7:0]  o_u_night,
	output logic [2:0][7:0]  o_v_night,
	output logic [2:0][7:0]  o_u_day,
	output logic [2:0][7:0]  o_v_day,
	output logic [2:0][11:0] o_lum_night,
	output logic [2:0][11:0] o_lum_day
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PUSH} state_t;

	localparam int TW = $clog2(TURN + 1);
	localparam logic [4:0] BASES [3] = '{RED_BASE, BLUE_BASE, GREEN_BASE};

	logic [7:0]       mem_q [MEM_DEPTH];
	state_t           state_q;
	state_t           state_d;
	logic [TW-1:0]    wait_q;
	logic [TW-1:0]    wait_d;
	logic [PTR_W-1:0] ptr_q;
	logic [PTR_W-1:0] ptr_d;
	logic [2:0]       idx_q;
	logic [2:0]       idx_d;
	logic             ready_q;
	logic             ready_d;
	logic             f_valid;
	logic             f_ready;
	logic [8:0]       f_data;
	logic [8:0]       f_out;
	logic [PTR_W:0]   addr;
	logic [7:0]       byte_rd;

	// one-time memory image, loaded through the program port
	always_ff @(posedge i_mclk)
	begin
		if (i_prog_we)
			mem_q[i_prog_addr] <= i_prog_data;
	end

	// address of the byte being pushed: descending from ptr+7
	always_comb
	begin
		addr = (PTR_W+1)'(ptr_q) + (PTR_W+1)'(3'(BURST_LEN - 1) - idx_q);
		if (addr > (PTR_W+1)'(LAST_ADDR))
			byte_rd = FILL_BYTE;
		else
			byte_rd = mem_q[addr[ADDR_W-1:0]];
	end

	// command sequencer
	always_comb
	begin
		state_d = state_q;
		wait_d  = wait_q;
		ptr_d   = ptr_q;
		idx_d   = idx_q;
		ready_d = ready_q;
		f_valid = 1'b0;
		f_data  = {(idx_q == 3'(BURST_LEN - 1)), byte_rd};
		case (state_q)
			ST_IDLE:
			begin
				ready_d = 1'b1;
				if (link.cmd_valid && ready_q)
				begin
					ptr_d   = link.cmd_arg[PTR_W-1:0];
					wait_d  = TW'(TURN);
					idx_d   = '0;
					ready_d = 1'b0;
					state_d = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (wait_q <= TW'(1))
					state_d = ST_PUSH;
				else
					wait_d = TW'(wait_q - 1'b1);
			end
			ST_PUSH:
			begin
				f_valid = 1'b1;
				if (f_ready)
				begin
					idx_d = 3'(idx_q + 1'b1);
					if (idx_q == 3'(BURST_LEN - 1))
					begin
						state_d = ST_IDLE;
						ready_d = 1'b1;
					end
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_q <= ST_IDLE;
			wait_q  <= '0;
			ptr_q   <= '0;
			idx_q   <= '0;
			ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wait_q  <= wait_d;
			ptr_q   <= ptr_d;
			idx_q   <= idx_d;
			ready_q <= ready_d;
		end
	end

	byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_mclk      (i_mclk),
		.i_rstn      (i_rstn),
		.i_in_valid  (f_valid),
		.o_in_ready  (f_ready),
		.i_in_data   (f_data),
		.o_out_valid (link.rsp_valid),
		.i_out_ready (link.rsp_ready),
		.o_out_data  (f_out)
	);

	assign link.rsp_byte  = f_out[7:0];
	assign link.rsp_last  = f_out[8];
	assign link.cmd_ready = ready_q;

	// decoded calibration views, registered
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_busy         <= 1'b0;
			o_die_position <= '0;
			o_wafer_number <= '0;
		end
		else
		begin
			o_busy         <= (state_q != ST_IDLE) || link.rsp_valid;
			o_die_position <= {mem_q[ID_MID_ADDR], mem_q[ID_LOW_ADDR]};
			o_wafer_number <= mem_q[ID_HIGH_ADDR][WAFER_W-1:0];
		end
	end

	// per colour channel fields
	for (genvar c = 0; c < 3; c++)
	begin : g_chan
		always_ff @(posedge i_mclk or negedge i_rstn)
		begin
			if (!i_rstn)
			begin
				o_u_night[c]   <= '0;
				o_v_night[c]   <= '0;
				o_u_day[c]     <= '0;
				o_v_day[c]     <= '0;
				o_lum_night[c] <= '0;
				o_lum_day[c]   <= '0;
			end
			else
			begin
				o_u_night[c]   <= mem_q[BASES[c] + OFS_U_NIGHT];
				o_v_night[c]   <= mem_q[BASES[c] + OFS_V_NIGHT];
				o_u_day[c]     <= mem_q[BASES[c] + OFS_U_DAY];
				o_v_day[c]     <= mem_q[BASES[c] + OFS_V_DAY];
				o_lum_night[c] <= {mem_q[BASES[c] + OFS_LUM_HIGH][3:0],
					mem_q[BASES[c] + OFS_LUM_NIGHT]};
				o_lum_day[c]   <= {mem_q[BASES[c] + OFS_LUM_HIGH][7:4],
					mem_q[BASES[c] + OFS_LUM_DAY]};
			end
		end
	end
endmodule // calib_responder
`default_nettype wire

/* calib_requester.sv */
`timescale 1ns/1ps
`default_nettype none
// host end: issues fetch commands and keeps a local copy
module calib_requester
	import calib_pkg::*;
#(
	parameter int TURN = TURN_CYC
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rstn,
	calib_link_if.host            link,
	input  wire logic             i_req_valid,
	input  wire logic [PTR_W-1:0] i_req_ptr,
	input  wire logic [4:0]       i_look_addr,
	output logic                  o_req_ready,
	output logic                  o_done,
	output logic [7:0]            o_look_data,
	output logic                  o_look_known,
	output logic [7:0]            o_check_byte
);
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_RECV} hstate_t;

	localparam int TW = $clog2(TURN + 1);

	logic [7:0]       copy_q [MEM_DEPTH];
	logic [MEM_DEPTH-1:0] known_q;
	logic [MEM_DEPTH-1:0] known_d;
	hstate_t          st_q;
	hstate_t          st_d;
	logic [TW-1:0]    cnt_q;
	logic [TW-1:0]    cnt_d;
	logic [PTR_W-1:0] ptr_q;
	logic [PTR_W-1:0] ptr_d;
	logic [PTR_W:0]   addr_q;
	logic [PTR_W:0]   addr_d;
	logic             done_d;
	logic             take;

	// request and response sequencer
	always_comb
	begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		ptr_d   = ptr_q;
		addr_d  = addr_q;
		known_d = known_q;
		done_d  = 1'b0;
		take    = (st_q == H_RECV) && link.rsp_valid;
		case (st_q)
			H_IDLE:
				if (i_req_valid)
				begin
					ptr_d = i_req_ptr;
					st_d  = H_SEND;
				end
			H_SEND:
				if (link.cmd_ready)
				begin
					cnt_d  = TW'(TURN);
					addr_d = (PTR_W+1)'(ptr_q) +
						(PTR_W+1)'(BURST_LEN - 1);
					st_d   = H_WAIT;
				end
			H_WAIT:
				if (cnt_q <= TW'(1))
					st_d = H_RECV;
				else
					cnt_d = TW'(cnt_q - 1'b1);
			H_RECV:
				if (take)
				begin
					if (addr_q <= (PTR_W+1)'(LAST_ADDR))
						known_d[addr_q[ADDR_W-1:0]] = 1'b1;
					addr_d = (PTR_W+1)'(addr_q - 1'b1);
					if (link.rsp_last)
					begin
						done_d = 1'b1;
						st_d   = H_IDLE;
					end
				end
			default:
				st_d = H_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_q    <= H_IDLE;
			cnt_q   <= '0;
			ptr_q   <= '0;
			addr_q  <= '0;
			known_q <= '0;
			o_done  <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			ptr_q   <= ptr_d;
			addr_q  <= addr_d;
			known_q <= known_d;
			o_done  <= done_d;
		end
	end

	// local copy of the device memory
	always_ff @(posedge i_mclk)
	begin
		if (take && addr_q <= (PTR_W+1)'(LAST_ADDR))
			copy_q[addr_q[ADDR_W-1:0]] <= link.rsp_byte;
	end

	// registered lookups into the copy
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_req_ready  <= 1'b0;
			o_look_data  <= '0;
			o_look_known <= 1'b0;
			o_check_byte <= '0;
		end
		else
		begin
			o_req_ready  <= (st_d == H_IDLE);
			o_look_data  <= copy_q[i_look_addr];
			o_look_known <= known_q[i_look_addr];
			o_check_byte <= known_q[CHECK_ADDR] ?
				copy_q[CHECK_ADDR] : 8'h00;
		end
	end

	assign link.cmd_valid = (st_q == H_SEND);
	assign link.cmd_arg   = {ARG_RSVD, ptr_q};
	assign link.rsp_ready = (st_q == H_RECV);
endmodule // calib_requester
`default_nettype wire

/* calib_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// link checker beside the interface joining both ends
module calib_monitor #(
	parameter int TURN = 20
) (
	input wire logic       i_mclk,
	input wire logic       i_rstn,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] cmd_arg,
	input wire logic       rsp_valid,
	input wire logic       rsp_ready,
	input wire logic [7:0] rsp_byte,
	input wire logic       rsp_last
);
	logic        take;
	logic        beat;
	logic [15:0] wait_q;
	logic [15:0] wait_d;
	logic [2:0]  cnt_q;
	logic [2:0]  cnt_d;
	assign take = cmd_valid && cmd_ready;
	assign beat = rsp_valid && rsp_ready;
	// cycles since command taken, bytes taken in burst
	always_comb
	begin
		wait_d = take ? 16'h0000 : wait_q + 16'h0001;
		cnt_d = beat ? cnt_q + 3'h1 : cnt_q;
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wait_q <= 16'h0000;
			cnt_q <= 3'h0;
		end
		else
		begin
			wait_q <= wait_d;
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);
	property p_arg_rsvd;
		cmd_valid |-> cmd_arg[7:6] == 2'h0;
	endproperty
	property p_cmd_hold;
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_arg);
	endproperty
	property p_one_cmd;
		take |=> !cmd_ready [*8];
	endproperty
	property p_quiet;
		take |=> !rsp_valid [*8];
	endproperty
	property p_turn;
		$rose(rsp_valid) |-> wait_q == 16'(TURN + 1);
	endproperty
	property p_rsp_hold;
		rsp_valid && !rsp_ready |=>
			rsp_valid && $stable({rsp_byte, rsp_last});
	endproperty
	property p_last_pos;
		rsp_valid |-> rsp_last == (cnt_q == 3'h7);
	endproperty
	property p_ready_back;
		beat && rsp_last |-> cmd_ready;
	endproperty
	a_arg_rsvd: assert property (p_arg_rsvd)
		else $error("reserved argument bits set");
	a_cmd_hold: assert property (p_cmd_hold)
		else $error("command changed before taken");
	a_one_cmd: assert property (p_one_cmd)
		else $error("command accepted during burst");
	a_quiet: assert property (p_quiet)
		else $error("answer too early");
	a_turn: assert property (p_turn)
		else $error("turnaround length wrong");
	a_rsp_hold: assert property (p_rsp_hold)
		else $error("stalled byte changed");
	a_last_pos: assert property (p_last_pos)
		else $error("last marker not on eighth byte");
	a_ready_back: assert property (p_ready_back)
		else $error("not ready after burst");
	c_take: cover property (take);
	c_last: cover property (beat && rsp_last);
	c_stall: cover property (rsp_valid && !rsp_ready [*8]);
endmodule // calib_monitor
`default_nettype wire

/* otp_calibration_readout_test.sv */
`timescale 1ns/1ps
`default_nettype none
// requester fetches bursts from responder across the link
module otp_calibration_readout_test
	import calib_pkg::*;
;
	localparam int T = 20;
	// host waits longer than the device so the byte queue fills and stalls
	localparam int HT = T + 12;
	logic                 i_mclk = 1'b0;
	logic                 i_rstn = 1'b0;
	logic                 prog_we = 1'b0;
	logic [4:0]           prog_addr = 5'h00;
	logic [7:0]           prog_data = 8'h00;
	logic                 req_valid = 1'b0;
	logic [PTR_W-1:0]     req_ptr = 6'h00;
	logic [4:0]           look_addr = 5'h10;
	logic                 busy;
	logic [15:0]          die_pos;
	logic [4:0]           wafer;
	logic [2:0][7:0]      u_n;
	logic [2:0][7:0]      v_n;
	logic [2:0][7:0]      u_d;
	logic [2:0][7:0]      v_d;
	logic [2:0][11:0]     lum_n;
	logic [2:0][11:0]     lum_d;
	logic                 done;
	logic                 req_ready;
	logic [7:0]           look_data;
	logic                 look_known;
	logic [7:0]           check_byte;
	logic [7:0]           mem [32];
	logic [7:0]           got [$];
	int                   failures = 0;
	int                   compares = 0;
	always #4 i_mclk = ~i_mclk;
	calib_link_if link ();
	calib_responder #(.TURN(T)) i_calib_responder (.i_mclk(i_mclk),
		.i_rstn(i_rstn), .link(link), .i_prog_we(prog_we),
		.i_prog_addr(prog_addr), .i_prog_data(prog_data), .o_busy(busy),
		.o_die_position(die_pos), .o_wafer_number(wafer), .o_u_night(u_n),
		.o_v_night(v_n), .o_u_day(u_d), .o_v_day(v_d),
		.o_lum_night(lum_n), .o_lum_day(lum_d));
	calib_requester #(.TURN(HT)) i_calib_requester (.i_mclk(i_mclk),
		.i_rstn(i_rstn), .link(link), .i_req_valid(req_valid),
		.i_req_ptr(req_ptr), .i_look_addr(look_addr),
		.o_req_ready(req_ready),
		.o_done(done), .o_look_data(look_data),
		.o_look_known(look_known), .o_check_byte(check_byte));
	calib_monitor #(.TURN(T)) i_calib_monitor (.i_mclk(i_mclk),
		.i_rstn(i_rstn), .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .cmd_arg(link.cmd_arg),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
		.rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last));
	// collect bytes crossing the link
	always @(posedge i_mclk)
		if (link.rsp_valid && link.rsp_ready)
			got.push_back(link.rsp_byte);
	task cmp(input string what, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask
	// expected byte at a location, fill beyond the map
	function automatic logic [7:0] exp_byte(input int a);
		return (a > 31) ? FILL_BYTE : mem[a];
	endfunction
	task tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one fetch, then check the burst and the local copy
	task fetch(input logic [5:0] p);
		int n;
		got.delete();
		@(posedge i_mclk);
		req_valid <= 1'b1;
		req_ptr <= p;
		@(posedge i_mclk);
		req_valid <= 1'b0;
		// command taken, both ends now waiting out the turnaround
		repeat (3) @(negedge i_mclk);
		cmp("busy_on", 16'h0001, 16'(busy));
		cmp("ready_off", 16'h0000, 16'(req_ready));
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(negedge i_mclk);
			n++;
		end
		cmp("done", 16'h0001, 16'(done));
		cmp("ready_on", 16'h0001, 16'(req_ready));
		cmp("count", 16'h0008, 16'(got.size()));
		for (int k = 0; k < 8; k++)
			cmp("byte", 16'(exp_byte(int'(p) + 7 - k)), 16'(got[k]));
		for (int k = 0; k < 8; k++)
			if (int'(p) + k < 32)
			begin
				@(posedge i_mclk);
				look_addr <= 5'(int'(p) + k);
				@(posedge i_mclk);
				@(negedge i_mclk);
				cmp("known", 16'h0001, 16'(look_known));
				cmp("copy", 16'(mem[int'(p) + k]), 16'(look_data));
			end
	endtask
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		failures++;
		tally_and_finish();
	end
	initial
	begin
		logic [7:0] v;
		int b;
		void'($urandom(1));
		repeat (4) @(posedge i_mclk);
		i_rstn <= 1'b1;
		// load the one-time memory with random bytes
		for (int a = 0; a < 32; a++)
		begin
			v = 8'($urandom);
			mem[a] = v;
			@(posedge i_mclk);
			prog_we <= 1'b1;
			prog_addr <= 5'(a);
			prog_data <= v;
		end
		@(posedge i_mclk);
		prog_we <= 1'b0;
		repeat (2) @(negedge i_mclk);
		cmp("unknown", 16'h0000, 16'(look_known));
		cmp("check0", 16'h0000, 16'(check_byte));
		cmp("die", {mem[1], mem[0]}, die_pos);
		cmp("wafer", 16'(mem[2][4:0]), 16'(wafer));
		for (int c = 0; c < 3; c++)
		begin
			b = 10 + 7 * c;
			cmp("u_n", 16'(mem[b]), 16'(u_n[c]));
			cmp("v_n", 16'(mem[b + 1]), 16'(v_n[c]));
			cmp("u_d", 16'(mem[b + 4]), 16'(u_d[c]));
			cmp("v_d", 16'(mem[b + 5]), 16'(v_d[c]));
			cmp("lum_n", {4'h0, mem[b + 3][3:0], mem[b + 2]}, 16'(lum_n[c]));
			cmp("lum_d", {4'h0, mem[b + 3][7:4], mem[b + 6]}, 16'(lum_d[c]));
		end
		fetch(6'h00);
		fetch(6'h18);
		cmp("check", 16'(mem[31]), 16'(check_byte));
		fetch(6'h1C);
		fetch(6'h3F);
		for (int r = 0; r < 4; r++)
			fetch(6'($urandom_range(0, 63)));
		// busy is registered, let the last pop reach it
		repeat (2) @(negedge i_mclk);
		cmp("busy", 16'h0000, 16'(busy));
		tally_and_finish();
	end
endmodule // otp_calibration_readout_test
`default_nettype wire
